// >>> src/osc_trip_pkg.sv
// package: constants, register map and types of the oscillation trip voter
package osc_trip_pkg;
   // ---------------------------------------------------------------
   // structure
   // ---------------------------------------------------------------
   localparam int NUM_CHAN = 4;
   localparam int CELLS_PER_CHAN = 2;
   localparam int NUM_CELLS = NUM_CHAN * CELLS_PER_CHAN;
   localparam int DETS_PER_CELL = 3;
   localparam int NUM_VOTERS = 4;
   localparam int DET_W = 16;
   localparam int SUM_W = 18;
   localparam int DEV_W = 19;
   // ---------------------------------------------------------------
   // operating window, in whole percent
   // ---------------------------------------------------------------
   localparam logic [7:0] POWER_MIN_PCT = 8'h1A; // 26 %
   localparam logic [7:0] FLOW_MAX_PCT = 8'h3C;  // 60 %
   // ---------------------------------------------------------------
   // algorithm constants; period limits in samples, filter as a shift, vote as a channel count
   // ---------------------------------------------------------------
   localparam int FILTER_SHIFT = 4;
   localparam logic [7:0] PERIOD_MIN_SAMPLES = 8'h0A;
   localparam logic [7:0] PERIOD_MAX_SAMPLES = 8'h3C;
   localparam int VOTE_MIN = 2;
   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] CELL_MAP_OFFSET = 8'h04;
   localparam logic [7:0] AMP_SETPOINT_OFFSET = 8'h08;
   localparam logic [7:0] PERIOD_SETPOINT_OFFSET = 8'h0C;
   localparam logic [7:0] GROWTH_SETPOINT_OFFSET = 8'h10;
   localparam logic [7:0] TEST_VALUE_OFFSET = 8'h14;
   localparam logic [7:0] STATUS_OFFSET = 8'h18;
   localparam logic [7:0] EVENT_OFFSET = 8'h1C;
   localparam logic [7:0] EVENT_MASK_OFFSET = 8'h20;
   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int CTRL_BYPASS_EN_BIT = 0;
   localparam int CTRL_BYPASS_SEL_LSB = 1;
   localparam int CTRL_TEST_EN_LSB = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [23:0] CELL_MAP_RESET = 24'h00_0000;
   localparam logic [DEV_W-1:0] AMP_SETPOINT_RESET = 19'h7_FFFF;
   localparam logic [3:0] PERIOD_SETPOINT_RESET = 4'hF;
   localparam logic [DEV_W-1:0] GROWTH_SETPOINT_RESET = 19'h7_FFFF;
   localparam logic [DET_W-1:0] TEST_VALUE_RESET = 16'h0000;
   localparam logic [13:0] EVENT_MASK_RESET = 14'h0000;
   // event bits: [3:0] channel trip rise, [7:4] alarm rise, [11:8] voter trip rise,
   // [12] window enable change, [13] half trip rise
   localparam int EVENT_W = 14;

   typedef struct packed {
      logic [NUM_CHAN-1:0] chan_trip;
      logic [NUM_CHAN-1:0] chan_alarm;
      logic [NUM_VOTERS-1:0] voter_trip;
      logic [NUM_VOTERS-1:0] half_trip;
      logic window_en;
   } status_t;
endpackage

// >>> src/osc_trip_voter.sv
// oscillation trip logic: cell averaging, algorithms, window, two-of-four voters, apb slave
// Operation
// - each cell sums up to three assigned detectors
// - sum unbypassed detectors, low-pass filter to average
// - period, amplitude, growth checks of sum versus average
// - any cell over setpoint trips its channel
// - power and flow come from average channel
// - trip only at power>=26% and flow<=60%
// - alarm when any algorithm fires on operable cell
// - oscillation and average trips voted separately
// - two unbypassed trips of one kind: all four voters trip
// - one unbypassed oscillation trip: half trip, no trip
// - bypass covers both channels, excluded from vote
// - relay drive active low, de-energize to trip
// - channel trip and alarm status presented
// - test signals injectable per channel
// - four channels feed four voters, two per system
`timescale 1ns/1ps
module osc_trip_voter
   import osc_trip_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sample_valid,
   input wire logic [osc_trip_pkg::NUM_CELLS*osc_trip_pkg::DETS_PER_CELL*osc_trip_pkg::DET_W-1:0] detector_data,
   input wire logic [7:0] thermal_power_pct,
   input wire logic [7:0] recirc_flow_pct,
   input wire logic [osc_trip_pkg::NUM_CHAN-1:0] average_power_channel_trip,
   output logic [osc_trip_pkg::NUM_CHAN-1:0] average_power_channel_bypass,
   output logic [osc_trip_pkg::NUM_VOTERS-1:0] trip_relay_n,
   output logic [osc_trip_pkg::NUM_VOTERS-1:0] half_trip,
   output logic [osc_trip_pkg::NUM_CHAN-1:0] chan_trip,
   output logic [osc_trip_pkg::NUM_CHAN-1:0] chan_alarm,
   output logic irq
);
   import osc_trip_pkg::*;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [31:0] ctrl;
   logic [23:0] cell_map;
   logic [DEV_W-1:0] amp_setpoint;
   logic [3:0] period_setpoint;
   logic [DEV_W-1:0] growth_setpoint;
   logic [DET_W-1:0] test_value;
   logic [EVENT_W-1:0] event_flags;
   logic [EVENT_W-1:0] event_mask;
   logic wr_en;
   logic rd_event;
   logic [EVENT_W-1:0] event_set;
   status_t status;
   logic window_en;
   logic processing_valid;
   logic [NUM_VOTERS-1:0] voter_trip;
   logic [NUM_CELLS-1:0] cell_amp;
   logic [NUM_CELLS-1:0] cell_period;
   logic [NUM_CELLS-1:0] cell_growth;
   logic [NUM_CELLS-1:0] cell_operable;
   logic [NUM_CHAN-1:0] bypass;
   logic [2:0] osc_count;
   logic [2:0] apc_count;

   // a write lands at the access edge, the only edge with pready high
   assign wr_en = psel & penable & pready & pwrite;
   assign rd_event = psel & penable & pready & ~pwrite & (paddr == EVENT_OFFSET);

   // ---------------------------------------------------------------
   // apb slave: one wait-free access cycle, answer prepared in setup
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            prdata <= 32'h0000_0000;
            unique case (paddr)
               CTRL_OFFSET: prdata <= ctrl;
               CELL_MAP_OFFSET: prdata <= {8'h00, cell_map};
               AMP_SETPOINT_OFFSET: prdata <= {13'h0000, amp_setpoint};
               PERIOD_SETPOINT_OFFSET: prdata <= {28'h000_0000, period_setpoint};
               GROWTH_SETPOINT_OFFSET: prdata <= {13'h0000, growth_setpoint};
               TEST_VALUE_OFFSET: prdata <= {16'h0000, test_value};
               STATUS_OFFSET: prdata <= {15'h0000, status};
               EVENT_OFFSET: prdata <= {18'h0_0000, event_flags};
               EVENT_MASK_OFFSET: prdata <= {18'h0_0000, event_mask};
               default: pslverr <= 1'b1; // unmapped address answers with an error
            endcase
         end
      end
   end

   // writes to read-only or unmapped words change nothing
   // configuration written by software; setpoints stay put while running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RESET;
         cell_map <= CELL_MAP_RESET;
         amp_setpoint <= AMP_SETPOINT_RESET;
         period_setpoint <= PERIOD_SETPOINT_RESET;
         growth_setpoint <= GROWTH_SETPOINT_RESET;
         test_value <= TEST_VALUE_RESET;
         event_mask <= EVENT_MASK_RESET;
      end else if (wr_en) begin
         unique case (paddr)
            CTRL_OFFSET: ctrl <= {24'h00_0000, pwdata[7:0]};
            CELL_MAP_OFFSET: cell_map <= pwdata[23:0];
            AMP_SETPOINT_OFFSET: amp_setpoint <= pwdata[DEV_W-1:0];
            PERIOD_SETPOINT_OFFSET: period_setpoint <= pwdata[3:0];
            GROWTH_SETPOINT_OFFSET: growth_setpoint <= pwdata[DEV_W-1:0];
            TEST_VALUE_OFFSET: test_value <= pwdata[DET_W-1:0];
            EVENT_MASK_OFFSET: event_mask <= pwdata[EVENT_W-1:0];
            default: ;
         endcase
      end
   end

   // limitation: only one channel can be bypassed at a time
   // one operator bypass covers both the oscillation and average channel
   always_comb begin
      bypass = '0;
      bypass[ctrl[CTRL_BYPASS_SEL_LSB +: 2]] = ctrl[CTRL_BYPASS_EN_BIT];
   end

   // ---------------------------------------------------------------
   // per-cell processing
   // ---------------------------------------------------------------
   for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
      localparam int CH = c / CELLS_PER_CHAN;
      logic [2:0] assign_mask;
      logic [SUM_W-1:0] sum;
      logic [SUM_W-1:0] avg;
      logic signed [DEV_W-1:0] dev;
      logic [DEV_W-1:0] mag;
      logic signed [DEV_W-1:0] dev_prev;
      logic [DEV_W-1:0] peak;
      logic [DEV_W-1:0] peak_prev;
      logic [7:0] interval;
      logic [3:0] confirm;
      logic up_cross;
      logic [DET_W-1:0] det [DETS_PER_CELL];

      assign assign_mask = cell_map[3*c +: 3];
      assign cell_operable[c] = |assign_mask;

      // test injection replaces every detector of the channel under test
      always_comb begin
         for (int d = 0; d < DETS_PER_CELL; d++) begin
            det[d] = ctrl[CTRL_TEST_EN_LSB + CH] ? test_value
                     : detector_data[(c*DETS_PER_CELL+d)*DET_W +: DET_W];
         end
      end

      // only assigned detectors enter the sum; unassigned act as bypassed
      always_comb begin
         sum = '0;
         for (int d = 0; d < DETS_PER_CELL; d++) begin
            if (assign_mask[d]) begin
               sum = sum + {2'b00, det[d]};
            end
         end
      end

      // deviation of the raw sum from its average feeds all three checks
      assign dev = $signed({1'b0, sum}) - $signed({1'b0, avg});
      assign mag = dev[DEV_W-1] ? DEV_W'(-dev) : DEV_W'(dev);
      assign up_cross = dev_prev[DEV_W-1] & ~dev[DEV_W-1];

      // first-order low-pass: avg += (sum - avg) / 16
      // a shift keeps the filter free of dividers, at the cost of slow settling
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            avg <= '0;
         end else if (sample_valid) begin
            avg <= SUM_W'($signed({1'b0, avg}) + (dev >>> FILTER_SHIFT));
         end
      end

      // full-cycle peak tracking between upward crossings and crossing interval for period and growth
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            dev_prev <= '0;
            peak <= '0;
            peak_prev <= '0;
            interval <= '0;
            confirm <= '0;
         end else if (sample_valid) begin
            dev_prev <= dev;
            if (up_cross) begin
               peak_prev <= peak;
               peak <= mag;
               interval <= 8'h01;
               // a steady period confirms another cycle; an odd one restarts the count
               if (interval >= PERIOD_MIN_SAMPLES && interval <= PERIOD_MAX_SAMPLES) begin
                  confirm <= (confirm == 4'hF) ? confirm : confirm + 4'h1;
               end else begin
                  confirm <= '0;
               end
            end else begin
               if (mag > peak) begin
                  peak <= mag;
               end
               if (interval != 8'hFF) begin
                  interval <= interval + 8'h01;
               end else begin
                  confirm <= '0; // oscillation died out
               end
            end
         end
      end

      // algorithm flags against the stored setpoints
      // a cell with an empty slot mask can neither alarm nor trip
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cell_amp[c] <= 1'b0;
            cell_period[c] <= 1'b0;
            cell_growth[c] <= 1'b0;
         end else if (sample_valid) begin
            cell_amp[c] <= cell_operable[c] & (mag > amp_setpoint);
            cell_period[c] <= cell_operable[c] & (confirm >= period_setpoint);
            cell_growth[c] <= cell_operable[c] & (peak > peak_prev)
                              & ((peak - peak_prev) > growth_setpoint);
         end
      end
   end

   // ---------------------------------------------------------------
   // operating window and channel trips, once per sample
   // ---------------------------------------------------------------
   // power and flow arrive already computed by the average channels
   // a change of power or flow counts only from the next sample on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         window_en <= 1'b0;
         processing_valid <= 1'b0;
      end else if (sample_valid) begin
         window_en <= (thermal_power_pct >= POWER_MIN_PCT)
                      && (recirc_flow_pct <= FLOW_MAX_PCT);
         processing_valid <= 1'b1;
      end
   end

   // alarm ignores the window so the operator still sees instability
   // trips lag their cell flags by one sample, so flags and window line up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_trip <= '0;
         chan_alarm <= '0;
      end else if (sample_valid) begin
         for (int ch = 0; ch < NUM_CHAN; ch++) begin
            chan_alarm[ch] <= |(cell_amp[ch*CELLS_PER_CHAN +: CELLS_PER_CHAN]
                                | cell_period[ch*CELLS_PER_CHAN +: CELLS_PER_CHAN]
                                | cell_growth[ch*CELLS_PER_CHAN +: CELLS_PER_CHAN]);
            chan_trip[ch] <= window_en & |(cell_amp[ch*CELLS_PER_CHAN +: CELLS_PER_CHAN]
                                | cell_period[ch*CELLS_PER_CHAN +: CELLS_PER_CHAN]
                                | cell_growth[ch*CELLS_PER_CHAN +: CELLS_PER_CHAN]);
         end
      end
   end

   // ---------------------------------------------------------------
   // two-of-four voters; each voter sees every channel
   // ---------------------------------------------------------------
   // unbypassed trips of each kind, counted apart so they never mix in one vote
   always_comb begin
      osc_count = '0;
      apc_count = '0;
      for (int ch = 0; ch < NUM_CHAN; ch++) begin
         osc_count = osc_count + {2'b00, chan_trip[ch] & ~bypass[ch]};
         apc_count = apc_count + {2'b00, average_power_channel_trip[ch] & ~bypass[ch]};
      end
   end

   // the relay drive follows the vote on every clock, not only at samples
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         voter_trip <= {NUM_VOTERS{1'b1}};
         half_trip <= '0;
         trip_relay_n <= '0; // relays de-energized: trip-safe
         average_power_channel_bypass <= '0;
      end else begin
         average_power_channel_bypass <= bypass;
         // separate counts: one trip of each kind never adds up to a vote
         for (int v = 0; v < NUM_VOTERS; v++) begin
            voter_trip[v] <= ~processing_valid | (osc_count >= 3'(VOTE_MIN))
                             | (apc_count >= 3'(VOTE_MIN));
            half_trip[v] <= (osc_count == 3'd1);
            trip_relay_n[v] <= processing_valid & (osc_count < 3'(VOTE_MIN))
                               & (apc_count < 3'(VOTE_MIN));
         end
      end
   end

   // status word as software reads it; the half trips of all voters are equal
   assign status = '{chan_trip: chan_trip, chan_alarm: chan_alarm, voter_trip: voter_trip,
                     half_trip: half_trip, window_en: window_en};

   // ---------------------------------------------------------------
   // sticky events, cleared by a read; a new event beats the clear
   // ---------------------------------------------------------------
   status_t status_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // reset image of status, so no false voter edge shows after release
         status_q <= '{chan_trip: '0,
                       chan_alarm: '0,
                       voter_trip: '1,
                       half_trip: '0,
                       window_en: 1'b0};
         event_flags <= '0;
         irq <= 1'b0;
      end else begin
         status_q <= status;
         event_flags <= (rd_event ? '0 : event_flags) | event_set;
         // irq follows the next flag value, so it never lags the flags
         irq <= |(((rd_event ? '0 : event_flags) | event_set) & event_mask);
      end
   end

   // rising edges of the status bits; the window bit flags either edge
   assign event_set = {|(status.half_trip & ~status_q.half_trip),
                       status.window_en ^ status_q.window_en,
                       status.voter_trip & ~status_q.voter_trip,
                       status.chan_alarm & ~status_q.chan_alarm,
                       status.chan_trip & ~status_q.chan_trip};
endmodule

// >>> bench/osc_trip_voter_props.sv
// checker: port-level properties of the oscillation trip voter
`timescale 1ns/1ps
module osc_trip_voter_props
   import osc_trip_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sample_valid,
   input wire logic [osc_trip_pkg::NUM_CHAN-1:0] average_power_channel_trip,
   input wire logic [osc_trip_pkg::NUM_CHAN-1:0] average_power_channel_bypass,
   input wire logic [osc_trip_pkg::NUM_VOTERS-1:0] trip_relay_n,
   input wire logic [osc_trip_pkg::NUM_VOTERS-1:0] half_trip,
   input wire logic [osc_trip_pkg::NUM_CHAN-1:0] chan_trip,
   input wire logic [osc_trip_pkg::NUM_CHAN-1:0] chan_alarm
);
   // ----------------------------------------
   // helper state and properties
   // ----------------------------------------
   logic seen_sample;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // relays may only energize once a sample has been processed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_sample <= 1'b0;
      end else if (sample_valid) begin
         seen_sample <= 1'b1;
      end
   end
   a_relay_safe_start: assert property (!seen_sample |-> trip_relay_n == 4'h0)
      else $error("relay energized before first sample");
   a_voters_agree: assert property (trip_relay_n == 4'h0 || trip_relay_n == 4'hF)
      else $error("voters disagree");
   a_half_agree: assert property (half_trip == 4'h0 || half_trip == 4'hF)
      else $error("half trips disagree");
   a_osc_two_trip: assert property (
      ($countones(chan_trip & ~average_power_channel_bypass) >= 2)[*2] |-> trip_relay_n == 4'h0)
      else $error("two channel trips did not trip relays");
   a_apc_two_trip: assert property (
      ($countones(average_power_channel_trip & ~average_power_channel_bypass) >= 2)[*2] |-> trip_relay_n == 4'h0)
      else $error("two average trips did not trip relays");
   a_one_half_trip: assert property (
      ($countones(chan_trip & ~average_power_channel_bypass) == 1
      && $countones(average_power_channel_trip & ~average_power_channel_bypass) < 2 && seen_sample)[*2]
      |-> trip_relay_n == 4'hF && half_trip == 4'hF)
      else $error("single trip not a half trip");
   a_trip_has_alarm: assert property ((chan_trip & ~chan_alarm) == 4'h0)
      else $error("trip without alarm");
   a_trip_on_sample: assert property ((chan_trip & ~$past(chan_trip)) != 4'h0 |-> $past(sample_valid))
      else $error("channel trip rose off a sample");
   a_pready_next: assert property (psel && !penable |=> pready)
      else $error("no ready in access cycle");
   a_unmapped_err: assert property (psel && penable && pready && paddr > 8'h20 |-> pslverr)
      else $error("unmapped access without error");
   a_bypass_single: assert property ($onehot0(average_power_channel_bypass))
      else $error("more than one bypassed channel");
   c_full_trip: cover property (seen_sample && trip_relay_n == 4'h0);
   c_half_trip: cover property (half_trip == 4'hF);
   c_slave_err: cover property (pready && pslverr);
endmodule
bind osc_trip_voter osc_trip_voter_props chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
   .average_power_channel_trip(average_power_channel_trip),
   .average_power_channel_bypass(average_power_channel_bypass), .trip_relay_n(trip_relay_n),
   .half_trip(half_trip), .chan_trip(chan_trip), .chan_alarm(chan_alarm));

// >>> bench/relay_panel_model.sv
// partner model: protection trip relays and operator bypass lamps
`timescale 1ns/1ps
module relay_panel_model
   import osc_trip_pkg::*;
(
   input wire logic [osc_trip_pkg::NUM_VOTERS-1:0] trip_relay_n,
   input wire logic [osc_trip_pkg::NUM_CHAN-1:0] average_power_channel_bypass,
   output logic [1:0] sys_trip,
   output logic [osc_trip_pkg::NUM_CHAN-1:0] lamp_bypass
);
   // a dropped coil trips its system, so a dead drive fails safe; voters 0,1 feed a, 2,3 feed b
   assign sys_trip[0] = ~(trip_relay_n[0] & trip_relay_n[1]);
   assign sys_trip[1] = ~(trip_relay_n[2] & trip_relay_n[3]);
   // lamp shows the channel taken out of both votes
   assign lamp_bypass = average_power_channel_bypass;
endmodule

// >>> bench/tb_oscillation_trip_voter.sv
// testbench: table of window and vote cases, then bypass, reset, register and interrupt tests
`timescale 1ns/1ps
module tb_oscillation_trip_voter;
   import osc_trip_pkg::*;
   typedef struct packed {
      logic [7:0] pw, fl;
      logic [3:0] tst, det, apc, trip, relay, half;
   } row_t;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sample_valid = 1'b0;
   logic [7:0] paddr = 8'h00, thermal_power_pct = 8'h00, recirc_flow_pct = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [NUM_CELLS*DETS_PER_CELL*DET_W-1:0] detector_data = '0;
   logic [NUM_CHAN-1:0] average_power_channel_trip = 4'h0, average_power_channel_bypass, chan_trip, chan_alarm;
   logic [NUM_CHAN-1:0] lamp_bypass, trip_relay_n, half_trip;
   logic pready, pslverr, irq, er;
   logic [1:0] sys_trip;
   int err_count = 0, tests_run = 0;
   row_t rows [6] = '{'{8'h1A, 8'h3C, 4'h1, 4'h0, 4'h0, 4'h1, 4'hF, 4'hF},
      '{8'h19, 8'h3C, 4'h3, 4'h0, 4'h0, 4'h0, 4'hF, 4'h0}, '{8'h1A, 8'h3D, 4'h3, 4'h0, 4'h0, 4'h0, 4'hF, 4'h0},
      '{8'h64, 8'h00, 4'h0, 4'h6, 4'h0, 4'h6, 4'h0, 4'h0}, '{8'h32, 8'h32, 4'h1, 4'h0, 4'h2, 4'h1, 4'hF, 4'hF},
      '{8'h32, 8'h32, 4'h0, 4'h0, 4'hC, 4'h0, 4'h0, 4'h0}};
   logic [7:0] reg_off [5] = '{CTRL_OFFSET, AMP_SETPOINT_OFFSET, PERIOD_SETPOINT_OFFSET, GROWTH_SETPOINT_OFFSET,
      EVENT_MASK_OFFSET};
   logic [31:0] reg_rst [5] = '{CTRL_RESET, 32'(AMP_SETPOINT_RESET), 32'(PERIOD_SETPOINT_RESET),
      32'(GROWTH_SETPOINT_RESET), 32'(EVENT_MASK_RESET)};
   // ----------------------------------------
   // clock, design and partner
   // ----------------------------------------
   always #20 pclk = ~pclk;
   osc_trip_voter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_valid(sample_valid), .detector_data(detector_data), .thermal_power_pct(thermal_power_pct),
      .recirc_flow_pct(recirc_flow_pct), .average_power_channel_trip(average_power_channel_trip),
      .average_power_channel_bypass(average_power_channel_bypass), .trip_relay_n(trip_relay_n),
      .half_trip(half_trip), .chan_trip(chan_trip), .chan_alarm(chan_alarm), .irq(irq));
   relay_panel_model panel (.trip_relay_n(trip_relay_n), .average_power_channel_bypass(average_power_channel_bypass),
      .sys_trip(sys_trip), .lamp_bypass(lamp_bypass));
   // compare tasks: four-bit signals and bus words
   task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t word %h exp %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      if (err_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // apb master: holds the request until ready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic do_reset();
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   // all cells on all slots; small setpoint so the first samples fire the amplitude check
   task automatic cfg(input logic [31:0] ctrl);
      apb(1'b1, CELL_MAP_OFFSET, 32'h00FF_FFFF);
      apb(1'b1, AMP_SETPOINT_OFFSET, 32'h0000_0100);
      apb(1'b1, TEST_VALUE_OFFSET, 32'h0000_1000);
      apb(1'b1, CTRL_OFFSET, ctrl);
   endtask
   task automatic two_samples();
      repeat (2) begin
         @(posedge pclk);
         sample_valid <= 1'b1;
         @(posedge pclk);
         sample_valid <= 1'b0;
         repeat (4) @(posedge pclk);
      end
   endtask
   // run is a few hundred cycles; this limit is far beyond it
   initial begin
      #2000000;
      err_count++;
      give_verdict();
   end
   initial begin
      foreach (rows[i]) begin
         do_reset();
         thermal_power_pct <= rows[i].pw;
         recirc_flow_pct <= rows[i].fl;
         average_power_channel_trip <= rows[i].apc;
         for (int c = 0; c < NUM_CELLS; c++) begin
            for (int d = 0; d < DETS_PER_CELL; d++) begin
               detector_data[(c*DETS_PER_CELL+d)*DET_W +: DET_W] <= rows[i].det[c/CELLS_PER_CHAN] ? 16'h1000 : 16'h0000;
            end
         end
         cfg({24'h0, rows[i].tst, 4'h0});
         two_samples();
         chk4(chan_trip, rows[i].trip);
         chk4(chan_alarm, rows[i].tst | rows[i].det);
         chk4(trip_relay_n, rows[i].relay);
         chk4(half_trip, rows[i].half);
         chk4({2'h0, sys_trip}, rows[i].relay == 4'h0 ? 4'h3 : 4'h0);
      end
      do_reset();
      average_power_channel_trip <= 4'h3;
      cfg(32'h0000_0033);
      two_samples();
      chk4(chan_trip, 4'h3);
      chk4(average_power_channel_bypass, 4'h2);
      chk4(lamp_bypass, 4'h2);
      chk4(trip_relay_n, 4'hF);
      chk4(half_trip, 4'hF);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk4(trip_relay_n, 4'h0);
      chk4(half_trip | chan_trip | {3'h0, irq}, 4'h0);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      chk4(trip_relay_n, 4'h0);
      for (int k = 0; k < 5; k++) begin
         apb(1'b0, reg_off[k], 32'h0);
         chk32(rd, reg_rst[k]);
         chk4({3'h0, er}, 4'h0);
      end
      apb(1'b1, 8'h24, 32'h0000_0001);
      chk4({3'h0, er}, 4'h1);
      apb(1'b1, AMP_SETPOINT_OFFSET, 32'h0000_0123);
      apb(1'b0, AMP_SETPOINT_OFFSET, 32'h0);
      chk32(rd, 32'h0000_0123);
      average_power_channel_trip <= 4'h0;
      cfg(32'h0000_0010);
      two_samples();
      chk4({3'h0, irq}, 4'h0);
      apb(1'b1, EVENT_MASK_OFFSET, 32'h0000_2001);
      repeat (2) @(posedge pclk);
      chk4({3'h0, irq}, 4'h1);
      apb(1'b0, EVENT_OFFSET, 32'h0);
      chk32(rd, 32'h0000_3011);
      repeat (2) @(posedge pclk);
      chk4({3'h0, irq}, 4'h0);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk32(rd, 32'h0000_221F);
      give_verdict();
   end
endmodule
